/* vfvpg_pkg.sv */
`default_nettype none
package vfvpg_pkg;
  // Register indices; byte address is index times four
  localparam int unsigned NREG = 23;
  localparam logic [4:0] R_CURVE_MODE                 = 5'h00;
  localparam logic [4:0] R_TORQUE_BOOST_LEVEL         = 5'h01;
  localparam logic [4:0] R_BOOST_CUTOFF_FREQUENCY     = 5'h02;
  localparam logic [4:0] R_CURVE_FREQ_POINT_ONE       = 5'h03;
  localparam logic [4:0] R_CURVE_VOLT_POINT_ONE       = 5'h04;
  localparam logic [4:0] R_CURVE_FREQ_POINT_TWO       = 5'h05;
  localparam logic [4:0] R_CURVE_VOLT_POINT_TWO       = 5'h06;
  localparam logic [4:0] R_CURVE_FREQ_POINT_THREE     = 5'h07;
  localparam logic [4:0] R_CURVE_VOLT_POINT_THREE     = 5'h08;
  localparam logic [4:0] R_SLIP_COMP_GAIN             = 5'h09;
  localparam logic [4:0] R_OVEREXCITATION_GAIN        = 5'h0a;
  localparam logic [4:0] R_OSCILLATION_DAMP_GAIN      = 5'h0b;
  localparam logic [4:0] R_SEPARATION_VOLTAGE_SOURCE  = 5'h0c;
  localparam logic [4:0] R_SEPARATION_VOLTAGE_DIGITAL = 5'h0d;
  localparam logic [4:0] R_SEPARATION_RISE_TIME       = 5'h0e;
  localparam logic [4:0] R_SEPARATION_DECLINE_TIME    = 5'h0f;
  localparam logic [4:0] R_SEPARATION_STOP_ORDER      = 5'h10;
  localparam logic [4:0] R_RATED_MOTOR_VOLTAGE        = 5'h11;
  localparam logic [4:0] R_RATED_MOTOR_FREQUENCY      = 5'h12;
  localparam logic [4:0] R_RATED_MOTOR_SPEED          = 5'h13;
  localparam logic [4:0] R_MOTOR_POLE_PAIRS           = 5'h14;
  localparam logic [4:0] R_STATOR_RESISTANCE          = 5'h15;
  localparam logic [4:0] R_RATED_MOTOR_CURRENT        = 5'h16;
  localparam logic [4:0] R_STATUS_VOLTAGE             = 5'h17;
  localparam logic [4:0] R_STATUS_FLAGS               = 5'h18;

  // Reset values, in register order
  localparam logic [15:0] RST_VAL [NREG] = '{
    16'h0000, 16'h0000, 16'h1388, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0078, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0ed8, 16'h1388, 16'h05b4, 16'h0002, 16'h01f4, 16'h0064};

  // Limits (0.1 % for percentages, 0.1 s for times)
  localparam logic [15:0] PCT_FULL  = 16'h03e8;
  localparam logic [15:0] PCT_HALF  = 16'h01f4;
  localparam logic [15:0] BOOST_MAX = 16'h012c;
  localparam logic [15:0] SLIP_MAX  = 16'h07d0;
  localparam logic [15:0] OVX_MAX   = 16'h00c8;
  localparam logic [15:0] OVX_DIV   = 16'h07d0;
  localparam logic [15:0] OSC_MAX   = 16'h0064;
  localparam logic [15:0] TIME_MAX  = 16'h2710;
  localparam logic [15:0] SRC_MAX   = 16'h0008;
  localparam logic [15:0] RPM_SCALE = 16'h0064;
  localparam logic [15:0] SEC_MIN   = 16'h003c;
  localparam logic [15:0] MOHM_DIV  = 16'h03e8;
  localparam logic [15:0] TENTHS    = 16'h000a;

  // Curve, separation source and stop order selection codes
  localparam logic [3:0] CURVE_LINE = 4'h0;
  localparam logic [3:0] CURVE_MULTI = 4'h1;
  localparam logic [3:0] CURVE_SQUARE = 4'h2;
  localparam logic [3:0] CURVE_FULL_SEP = 4'ha;
  localparam logic [3:0] CURVE_SEMI_SEP = 4'hb;
  localparam logic [3:0] SRC_DIGITAL = 4'h0;
  localparam logic [0:0] STOP_VOLT_FIRST = 1'b1;

  // Control tick of the voltage ramp
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned TICK_NS        = 1_000_000;
  localparam int unsigned TICK_CYC_DEF   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_DSEC = 100_000_000 / TICK_NS;

  // Setpoints in 0.1 %, signed, from logic on the same clock
  typedef struct packed {
    logic signed [15:0] analog_input_one;
    logic signed [15:0] analog_input_two;
    logic signed [15:0] analog_input_three;
    logic signed [15:0] pulse_input_terminal;
    logic signed [15:0] multistep;
    logic signed [15:0] sequencer;
    logic signed [15:0] pid;
    logic signed [15:0] host;
  } vfvpg_src_t;

  typedef struct packed {
    logic [15:0]        voltage_cmd;
    logic [15:0]        slip_freq_add;
    logic signed [15:0] osc_freq_corr;
    logic               freq_hold;
    logic               boost_active;
  } vfvpg_drive_t;
endpackage
`default_nettype wire

/* vfvpg_top.sv */
`timescale 1ns/100ps
`default_nettype none
module vfvpg_top
  import vfvpg_pkg::*;
#(
  parameter int unsigned ADDR_W      = 8,
  parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire vfvpg_src_t        setpoints,
  input  wire logic [15:0]       output_frequency,
  input  wire logic              run_cmd,
  input  wire logic              decelerating,
  input  wire logic [15:0]       load_pct,
  input  wire logic signed [15:0] osc_current_dev,
  output vfvpg_drive_t           drive
);

  if (ADDR_W < 7 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W must cover the register map");
  end
  if (TICK_CYCLES < 1) begin : g_chk_tick
    $error("TICK_CYCLES must be at least one");
  end

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam logic [31:0] DSEC_TICKS = 32'(TICKS_PER_DSEC);

  logic [15:0] regs_q [NREG];

  // Saturating a*b/div; div is never zero at any call site
  function automatic logic [15:0] scale(input logic [15:0] a, input logic [15:0] b,
                                        input logic [15:0] div);
    logic [31:0] p;
    p = ({16'h0000, a} * {16'h0000, b}) / {16'h0000, div};
    return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [15:0] pct_abs(input logic signed [15:0] x);
    logic [15:0] m;
    m = x[15] ? 16'(-x) : 16'(x);
    return min16(m, PCT_FULL);
  endfunction

  // Linear interpolation of voltage against frequency on one segment
  function automatic logic [15:0] interp(input logic [15:0] f, input logic [15:0] fa,
                                         input logic [15:0] fb, input logic [15:0] va,
                                         input logic [15:0] vb);
    logic [15:0] d;
    if (fb <= fa) begin
      return vb;
    end
    d = scale((vb >= va) ? vb - va : va - vb, f - fa, fb - fa);
    return (vb >= va) ? va + d : va - d;
  endfunction

  // Curve weight of the square term, in tenths, for the power curves
  function automatic logic [15:0] pow_weight(input logic [3:0] code);
    case (code)
      4'h2:    return 16'h000a;
      4'h3:    return 16'h0002;
      4'h4:    return 16'h0004;
      4'h6:    return 16'h0006;
      4'h8:    return 16'h0008;
      default: return 16'h0000;
    endcase
  endfunction

  // ---------------- AXI4-Lite slave ----------------
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  wire         wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire         rd_go   = s_axi_arvalid & ~rvalid_q;
  wire [4:0]   wr_idx  = s_axi_awaddr[6:2];
  wire [4:0]   rd_idx  = s_axi_araddr[6:2];
  wire         wr_hi_z = (ADDR_W > 7) ? (s_axi_awaddr >> 7) == '0 : 1'b1;
  wire         rd_hi_z = (ADDR_W > 7) ? (s_axi_araddr >> 7) == '0 : 1'b1;
  wire         wr_map  = wr_hi_z && (32'(wr_idx) < NREG);
  wire         rd_map  = rd_hi_z && (rd_idx <= R_STATUS_FLAGS);

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  wire [15:0] wr_old = (wr_idx < 5'(NREG)) ? regs_q[wr_idx] : 16'h0000;
  wire [15:0] wr_raw = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : wr_old[15:8],
                        s_axi_wstrb[0] ? s_axi_wdata[7:0]  : wr_old[7:0]};

  wire [15:0] rv   = regs_q[R_RATED_MOTOR_VOLTAGE];
  wire [15:0] rf   = regs_q[R_RATED_MOTOR_FREQUENCY];
  wire [15:0] rv_c = (rv == 16'h0000) ? 16'h0001 : rv;
  wire [15:0] rf_c = (rf == 16'h0000) ? 16'h0001 : rf;
  wire [15:0] f1   = regs_q[R_CURVE_FREQ_POINT_ONE];
  wire [15:0] f2   = regs_q[R_CURVE_FREQ_POINT_TWO];
  wire [15:0] f3   = regs_q[R_CURVE_FREQ_POINT_THREE];

  // Written values are held inside their documented ranges
  logic [15:0] wr_val;
  always_comb begin
    case (wr_idx)
      R_CURVE_MODE:                 wr_val = {12'h000, wr_raw[3:0]};
      R_TORQUE_BOOST_LEVEL:         wr_val = min16(wr_raw, BOOST_MAX);
      R_CURVE_FREQ_POINT_ONE:       wr_val = min16(wr_raw, f2);
      R_CURVE_FREQ_POINT_TWO:       wr_val = (wr_raw < f1) ? f1 : min16(wr_raw, f3);
      R_CURVE_FREQ_POINT_THREE:     wr_val = (wr_raw < f2) ? f2 : min16(wr_raw, rf);
      R_CURVE_VOLT_POINT_ONE,
      R_CURVE_VOLT_POINT_TWO,
      R_CURVE_VOLT_POINT_THREE:     wr_val = min16(wr_raw, PCT_FULL);
      R_SLIP_COMP_GAIN:             wr_val = min16(wr_raw, SLIP_MAX);
      R_OVEREXCITATION_GAIN:        wr_val = min16(wr_raw, OVX_MAX);
      R_OSCILLATION_DAMP_GAIN:      wr_val = min16(wr_raw, OSC_MAX);
      R_SEPARATION_VOLTAGE_SOURCE:  wr_val = min16(wr_raw, SRC_MAX);
      R_SEPARATION_VOLTAGE_DIGITAL: wr_val = min16(wr_raw, rv);
      R_SEPARATION_RISE_TIME,
      R_SEPARATION_DECLINE_TIME:    wr_val = min16(wr_raw, TIME_MAX);
      R_SEPARATION_STOP_ORDER:      wr_val = {15'h0000, wr_raw[0]};
      default:                      wr_val = wr_raw;
    endcase
  end

  for (genvar gi = 0; gi < NREG; gi++) begin : g_reg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs_q[gi] <= RST_VAL[gi];
      end else if (wr_go && wr_map && wr_idx == 5'(gi)) begin
        regs_q[gi] <= wr_val;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------- Voltage computation ----------------
  wire [3:0]  curve    = regs_q[R_CURVE_MODE][3:0];
  wire [15:0] f        = output_frequency;
  wire        sep_full = (curve == CURVE_FULL_SEP);
  wire        sep_semi = (curve == CURVE_SEMI_SEP);

  logic [15:0] src_pct;
  always_comb begin
    case (regs_q[R_SEPARATION_VOLTAGE_SOURCE][3:0])
      4'h1:    src_pct = pct_abs(setpoints.analog_input_one);
      4'h2:    src_pct = pct_abs(setpoints.analog_input_two);
      4'h3:    src_pct = pct_abs(setpoints.analog_input_three);
      4'h4:    src_pct = pct_abs(setpoints.pulse_input_terminal);
      4'h5:    src_pct = pct_abs(setpoints.multistep);
      4'h6:    src_pct = pct_abs(setpoints.sequencer);
      4'h7:    src_pct = pct_abs(setpoints.pid);
      4'h8:    src_pct = pct_abs(setpoints.host);
      default: src_pct = 16'h0000;
    endcase
  end

  wire        src_dig  = regs_q[R_SEPARATION_VOLTAGE_SOURCE][3:0] == SRC_DIGITAL;
  wire [15:0] sep_volt = src_dig ? regs_q[R_SEPARATION_VOLTAGE_DIGITAL]
                                 : scale(src_pct, rv, PCT_FULL);

  // Fraction of rated frequency, saturating at rated
  wire [15:0] lin_pct = (f >= rf) ? PCT_FULL : scale(f, PCT_FULL, rf_c);
  wire [15:0] sq_pct  = scale(lin_pct, lin_pct, PCT_FULL);
  // Power curves blend between line and square, sq_pct never exceeds lin_pct
  wire [15:0] pw_pct  = lin_pct - scale(lin_pct - sq_pct, pow_weight(curve), TENTHS);
  wire [15:0] v1      = regs_q[R_CURVE_VOLT_POINT_ONE];
  wire [15:0] v2      = regs_q[R_CURVE_VOLT_POINT_TWO];
  wire [15:0] v3      = regs_q[R_CURVE_VOLT_POINT_THREE];
  wire [15:0] mp_pct  = (f < f1) ? interp(f, 16'h0000, f1, 16'h0000, v1) :
                        (f < f2) ? interp(f, f1, f2, v1, v2) :
                        (f < f3) ? interp(f, f2, f3, v2, v3) :
                        (f < rf) ? interp(f, f3, rf, v3, PCT_FULL) : PCT_FULL;
  // V/F = 2 * X * Vrated / Frated, capped at rated voltage
  wire [15:0] semi_pct = min16(scale(src_pct, lin_pct, PCT_HALF), PCT_FULL);

  logic [15:0] curve_pct;
  always_comb begin
    case (curve)
      CURVE_LINE:     curve_pct = lin_pct;
      CURVE_MULTI:    curve_pct = mp_pct;
      CURVE_SEMI_SEP: curve_pct = semi_pct;
      default:        curve_pct = pw_pct;
    endcase
  end

  wire [15:0] curve_volt = scale(curve_pct, rv, PCT_FULL);
  wire [15:0] boost_lvl  = regs_q[R_TORQUE_BOOST_LEVEL];
  wire        boost_on   = f < regs_q[R_BOOST_CUTOFF_FREQUENCY];
  // Automatic boost is the stator drop at rated current: 0.1 A times mohm to 0.1 V
  wire [15:0] auto_boost = scale(regs_q[R_STATOR_RESISTANCE],
                                 regs_q[R_RATED_MOTOR_CURRENT], MOHM_DIV);
  wire [15:0] man_boost  = scale(boost_lvl, rv, PCT_FULL);
  wire [15:0] boost_volt = !boost_on ? 16'h0000 :
                           (boost_lvl == 16'h0000) ? auto_boost : man_boost;
  wire [15:0] ovx_volt   = decelerating ?
                           scale(curve_volt, regs_q[R_OVEREXCITATION_GAIN], OVX_DIV) :
                           16'h0000;
  wire [17:0] vf_sum     = 18'(curve_volt) + 18'(boost_volt) + 18'(ovx_volt);
  wire [15:0] vf_volt    = (vf_sum > 18'(rv)) ? rv : vf_sum[15:0];

  // ---------------- Separation ramp ----------------
  logic [31:0] tick_cnt_q;
  logic [31:0] ramp_q;
  wire         tick       = (tick_cnt_q == TICK_LAST);
  wire [15:0]  rise_t     = regs_q[R_SEPARATION_RISE_TIME];
  wire [15:0]  fall_t     = regs_q[R_SEPARATION_DECLINE_TIME];
  wire [31:0]  ramp_tgt   = {(run_cmd ? sep_volt : 16'h0000), 16'h0000};
  wire [31:0]  full_q     = {rv_c, 16'h0000};
  wire [31:0]  up_div     = 32'(rise_t) * DSEC_TICKS;
  wire [31:0]  dn_div     = 32'(fall_t) * DSEC_TICKS;
  // Step per tick so a full-scale swing spans the set time, at least one lsb
  wire [31:0]  up_raw     = (up_div == 32'h0) ? full_q : full_q / up_div;
  wire [31:0]  dn_raw     = (dn_div == 32'h0) ? full_q : full_q / dn_div;
  wire [31:0]  up_step    = (up_raw == 32'h0) ? 32'h1 : up_raw;
  wire [31:0]  dn_step    = (dn_raw == 32'h0) ? 32'h1 : dn_raw;
  wire         go_up      = ramp_tgt > ramp_q;
  wire         go_dn      = ramp_tgt < ramp_q;
  wire         up_now     = go_up && (tick || rise_t == 16'h0000);
  wire         dn_now     = go_dn && (tick || fall_t == 16'h0000);
  wire [31:0]  gap        = go_up ? ramp_tgt - ramp_q : ramp_q - ramp_tgt;
  wire         up_snap    = (rise_t == 16'h0000) || gap <= up_step;
  wire         dn_snap    = (fall_t == 16'h0000) || gap <= dn_step;

  logic [31:0] ramp_d;
  always_comb begin
    if (!sep_full) begin
      ramp_d = 32'h0;
    end else if (up_now) begin
      ramp_d = up_snap ? ramp_tgt : ramp_q + up_step;
    end else if (dn_now) begin
      ramp_d = dn_snap ? ramp_tgt : ramp_q - dn_step;
    end else begin
      ramp_d = ramp_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0;
      ramp_q     <= 32'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      ramp_q     <= ramp_d;
    end
  end

  // Order 1 holds frequency until the separated voltage has reached zero
  wire freq_hold = sep_full && !run_cmd && ramp_q[31:16] != 16'h0000 &&
                   regs_q[R_SEPARATION_STOP_ORDER][0] == STOP_VOLT_FIRST;

  // ---------------- Slip and oscillation ----------------
  wire [31:0] sync_cf    = (32'(regs_q[R_RATED_MOTOR_SPEED]) * 32'(regs_q[R_MOTOR_POLE_PAIRS])
                           * 32'(RPM_SCALE)) / 32'(SEC_MIN);
  wire [15:0] rated_slip = (sync_cf >= 32'(rf)) ? 16'h0000 : rf - sync_cf[15:0];
  wire [15:0] slip_g     = scale(rated_slip, regs_q[R_SLIP_COMP_GAIN], PCT_FULL);
  wire [15:0] slip_add   = scale(slip_g, load_pct, PCT_FULL);
  wire [15:0] dev_mag    = osc_current_dev[15] ? 16'(-osc_current_dev) : 16'(osc_current_dev);
  wire [15:0] damp_mag   = min16(scale(dev_mag, regs_q[R_OSCILLATION_DAMP_GAIN], OSC_MAX),
                                 16'h7fff);
  wire signed [15:0] osc_corr = osc_current_dev[15] ? $signed(damp_mag) : -$signed(damp_mag);

  vfvpg_drive_t drive_d;
  always_comb begin
    drive_d.voltage_cmd   = sep_full ? ramp_q[31:16] : vf_volt;
    drive_d.slip_freq_add = (sep_full || sep_semi) ? 16'h0000 : slip_add;
    drive_d.osc_freq_corr = osc_corr;
    drive_d.freq_hold     = freq_hold;
    drive_d.boost_active  = !sep_full && boost_volt != 16'h0000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
    end else begin
      drive <= drive_d;
    end
  end

  // ---------------- Read path ----------------
  wire [15:0] flags    = {13'h0000, sep_full && (go_up || go_dn), drive.boost_active,
                          drive.freq_hold};
  wire [15:0] rd_value = (rd_idx == R_STATUS_VOLTAGE) ? drive.voltage_cmd :
                         (rd_idx == R_STATUS_FLAGS)   ? flags :
                         (32'(rd_idx) < NREG)         ? regs_q[rd_idx] : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= rd_map ? {16'h0000, rd_value} : 32'h0;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // vfvpg_top
`default_nettype wire

/* vfvpg_top_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module vfvpg_top_chk
  import vfvpg_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic         run_cmd,
  input wire vfvpg_drive_t drive
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_aw_gate: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
    else $error("write accepted out of turn");
  a_w_paired: assert property (s_axi_wready == s_axi_awready)
    else $error("address and data taken apart");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_hold_stop: assert property (drive.freq_hold |-> !$past(run_cmd))
    else $error("frequency hold while running");
endmodule // vfvpg_top_chk
bind vfvpg_top vfvpg_top_chk vfvpg_top_chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .run_cmd, .drive);
`default_nettype wire

/* vfvpg_plant.sv */
`timescale 1ns/100ps
`default_nettype none
module vfvpg_plant (
  input wire logic  aclk,
  input wire logic  aresetn,
  input wire logic  run_cmd,
  input wire logic  freq_hold,
  input wire logic  [15:0] target_freq,
  output logic      [15:0] output_frequency,
  output logic      decelerating
);
  logic [15:0] freq_q;
  logic        run_q;
  // Run is acted on one cycle late, in step with the registered drive outputs
  assign output_frequency = freq_q;
  assign decelerating = !run_q && freq_q != 16'h0000 && !freq_hold;
  always_ff @(posedge aclk) begin
    run_q <= aresetn && run_cmd;
    if (!aresetn)
      freq_q <= 16'h0000;
    else if (run_q)
      freq_q <= (target_freq - freq_q > 16'h0064) ? freq_q + 16'h0064 : target_freq;
    else if (!freq_hold)
      freq_q <= (freq_q > 16'h0064) ? freq_q - 16'h0064 : 16'h0000;
  end
endmodule // vfvpg_plant
`default_nettype wire

/* vfvpg_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module vfvpg_top_tb
  import vfvpg_pkg::*;
();
  logic aclk = 1'b0, aresetn = 1'b0, run_cmd = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, decel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] freq;
  logic [15:0] osc = 16'h0000;
  vfvpg_src_t sp = '0;
  vfvpg_drive_t drive;
  int fail_count = 0, checked = 0;
  logic [4:0] ci [9] = '{5'h01, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h0f, 5'h04, 5'h0d};
  logic [15:0] cv [9] = '{16'h0190, 16'h0bb8, 16'h012c, 16'h00c8, 16'h0009, 16'h4e20,
                          16'h4e20, 16'h04b0, 16'h1388};
  logic [15:0] ce [9] = '{16'h012c, 16'h07d0, 16'h00c8, 16'h0064, 16'h0008, 16'h2710,
                          16'h2710, 16'h03e8, 16'h0ed8};
  vfvpg_top #(.TICK_CYCLES(20)) vfvpg_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .setpoints(sp), .output_frequency(freq),
    .run_cmd, .decelerating(decel), .load_pct(16'h03e8), .osc_current_dev(osc), .drive);
  vfvpg_plant vfvpg_plant_i (.aclk, .aresetn, .run_cmd, .freq_hold(drive.freq_hold),
    .target_freq(16'h09c4), .output_frequency(freq), .decelerating(decel));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic vchk(input string n, input logic [15:0] e);
    chk(n, {16'h0000, e}, {16'h0000, drive.voltage_cmd});
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {1'b0, i, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [4:0] i, input logic [15:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {1'b0, i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", {16'h0000, e}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #150000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    for (int k = 1; k < 9; k++) sp[(8 - k) * 16 +: 16] <= 16'(-100 * k);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < NREG; k++) rd(5'(k), RST_VAL[k], 2'b00);
    rd(5'h19, 16'h0000, 2'b10);
    wr(5'h17, 16'h0001, 2'b10);
    $display("test reset_values done");
    for (int k = 0; k < 9; k++) begin
      wr(ci[k], cv[k], 2'b00);
      rd(ci[k], ce[k], 2'b00);
    end
    $display("test clamps done");
    wr(5'h00, 16'h000a, 2'b00);
    wr(5'h0e, 16'h0000, 2'b00);
    wr(5'h0f, 16'h0000, 2'b00);
    wr(5'h0d, 16'h03e8, 2'b00);
    run_cmd <= 1'b1;
    for (int s = 0; s < 9; s++) begin
      wr(5'h0c, 16'(s), 2'b00);
      repeat (4) @(posedge aclk);
      vchk("sep_voltage", (s == 0) ? 16'h03e8 : 16'(380 * s));
    end
    $display("test sources done");
    wr(5'h0c, 16'h0000, 2'b00);
    wr(5'h0e, 16'h0001, 2'b00);
    wr(5'h0f, 16'h0002, 2'b00);
    wr(5'h10, 16'h0001, 2'b00);
    wr(5'h0d, 16'h0ed8, 2'b00);
    repeat (1000) @(posedge aclk);
    chk("rise_mid", 1, 32'(drive.voltage_cmd > 16'h03e8 && drive.voltage_cmd < 16'h0ed8));
    repeat (1200) @(posedge aclk);
    vchk("rise_end", 16'h0ed8);
    run_cmd <= 1'b0;
    repeat (2000) @(posedge aclk);
    chk("freq_hold", 1, 32'(drive.freq_hold));
    chk("freq_held", 32'h09c4, {16'h0000, freq});
    repeat (2300) @(posedge aclk);
    vchk("decline_end", 16'h0000);
    repeat (40) @(posedge aclk);
    chk("freq_after", 0, {16'h0000, freq});
    wr(5'h10, 16'h0000, 2'b00);
    wr(5'h0e, 16'h0000, 2'b00);
    run_cmd <= 1'b1;
    repeat (30) @(posedge aclk);
    run_cmd <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("no_hold", 0, 32'(drive.freq_hold));
    chk("both_fall", 1, 32'(freq < 16'h09c4 && drive.voltage_cmd > 16'h0e00));
    repeat (4100) @(posedge aclk);
    vchk("stop_end", 16'h0000);
    $display("test stop_order done");
    wr(5'h00, 16'h000b, 2'b00);
    wr(5'h02, 16'h0000, 2'b00);
    wr(5'h0c, 16'h0001, 2'b00);
    run_cmd <= 1'b1;
    repeat (40) @(posedge aclk);
    vchk("semi", 16'h017c);
    chk("boost_off", 0, 32'(drive.boost_active));
    wr(5'h02, 16'h1388, 2'b00);
    for (int b = 0; b < 2; b++) begin
      wr(5'h01, b ? 16'h0064 : 16'h0000, 2'b00);
      repeat (4) @(posedge aclk);
      chk("boost_on", 1, 32'(drive.boost_active));
      chk("boosted", 1, 32'(drive.voltage_cmd > 16'h017c));
    end
    $display("test semi_boost done");
    wr(5'h00, 16'h0001, 2'b00);
    wr(5'h02, 16'h0000, 2'b00);
    wr(5'h07, 16'h0fa0, 2'b00);
    wr(5'h05, 16'h0bb8, 2'b00);
    wr(5'h03, 16'h03e8, 2'b00);
    wr(5'h04, 16'h00c8, 2'b00);
    wr(5'h06, 16'h0190, 2'b00);
    wr(5'h08, 16'h02bc, 2'b00);
    osc <= 16'h0032;
    repeat (4) @(posedge aclk);
    vchk("multi_point", 16'h0532);
    chk("slip_add", 32'h0000010c, {16'h0000, drive.slip_freq_add});
    chk("osc_corr", 32'h0000ffce, {16'h0000, drive.osc_freq_corr});
    $display("test multi_point done");
    report_and_stop();
  end
endmodule // vfvpg_top_tb
`default_nettype wire
